// >>> hdl/uib_params.svh
// Purpose: Offsets, field positions, reset values and counts of the block.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte addresses of one aligned 32-bit word per register.
`ifndef UIB_PARAMS_SVH
`define UIB_PARAMS_SVH

`define UIB_OFS_IDENT       12'h000
`define UIB_OFS_ENABLE      12'h004
`define UIB_OFS_DIV_LOW     12'h008
`define UIB_OFS_DIV_HIGH    12'h00C
`define UIB_OFS_SCRATCH     12'h010
`define UIB_OFS_CONFIG      12'h014

`define UIB_CFG_FIFO_EN     0
`define UIB_CFG_IRQ_OUT_EN  3
`define UIB_CFG_TRIG_LO     6
`define UIB_CFG_TRIG_HI     7
`define UIB_CFG_HS_LO       8
`define UIB_CFG_HS_HI       9
`define UIB_CFG_MASK        32'h0000_03C9

`define UIB_RST_DIV_LOW     8'h01
`define UIB_RST_DIV_HIGH    8'h00
`define UIB_RST_ENABLE      4'h0
`define UIB_RST_SCRATCH     8'h00
`define UIB_RST_CONFIG      10'h000

`define UIB_TRIG_00         5'h01
`define UIB_TRIG_01         5'h04
`define UIB_TRIG_10         5'h08
`define UIB_TRIG_11         5'h0E

`define UIB_REF_HZ          24000000
`define UIB_NORM_HZ         1846100
`define UIB_CHAR_TIMES      4
`define UIB_TICKS_PER_CHAR  160

`endif

// >>> hdl/uib_pkg.sv
// Purpose: Types shared by the interrupt identification and baud block.
// Assumes: Constants live in uib_params.svh.
// Notes:   Identification codes are the low nibble read back.
`default_nettype none
package uib_pkg;
	typedef enum logic [3:0] {
		UIB_ID_NONE = 4'b0001,
		UIB_ID_LINE = 4'b0110,
		UIB_ID_RXD  = 4'b0100,
		UIB_ID_TMO  = 4'b1100,
		UIB_ID_TXE  = 4'b0010,
		UIB_ID_HSK  = 4'b0000
	} uib_ident_t;
	typedef enum logic [1:0] {
		UIB_TR_IDLE   = 2'b00,
		UIB_TR_BUSY   = 2'b01,
		UIB_TR_NONSEQ = 2'b10,
		UIB_TR_SEQ    = 2'b11
	} uib_htrans_t;
endpackage
`default_nettype wire

// >>> hdl/uib_top.sv
// Purpose: Interrupt identification, enable gating and baud generation.
// Assumes: AHB-Lite slave, zero wait states; neighbours on clk_sys.
// Notes:   Only the 24 MHz reference pin crosses into clk_sys.
// Operation
// - Ident bits 7:6 set in FIFO mode
// - Ident bits 5:4 always read zero
// - Bit 3 only for FIFO time-out
// - Bit 0 low when pending; priority code
// - Line errors highest, cleared by status read
// - Data ready or trigger level, second
// - Four character time-out, cleared by read
// - Tx empty cleared by write or ident
// - Modem changes lowest, cleared by status read
// - Enable upper nibble reads zero
// - Enable bits select four sources
// - Sources drive output only when enabled
// - 24 MHz over 13, then divisor
// - Output is sixteen times baud rate
// - High speed divides 24 MHz directly
// - Scratch byte reads back last write
// - Output gated by master irq enable
// - Config bit zero enables FIFO mode
// - Trigger level 1,4,8,14 bytes
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`include "uib_params.svh"
`timescale 1ns/1ns
`default_nettype none

module uib_top #(
	parameter int unsigned PRESCALE  = `UIB_REF_HZ / `UIB_NORM_HZ,
	parameter int unsigned TMO_TICKS = `UIB_CHAR_TIMES * `UIB_TICKS_PER_CHAR
) (
	// Clock, reset, enable.
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        ce,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Reference clock pin.
	input  wire logic        ref_clk_24m,
	// Line status events.
	input  wire logic        overrun_flag,
	input  wire logic        parity_error_flag,
	input  wire logic        missing_stop_flag,
	input  wire logic        break_detect_flag,
	input  wire logic        line_status_rd,
	// Receive side.
	input  wire logic        rx_data_ready,
	input  wire logic [4:0]  rx_fifo_count,
	input  wire logic        rx_push,
	input  wire logic        receive_buffer_rd,
	// Transmit side.
	input  wire logic        tx_empty_evt,
	input  wire logic        transmit_buffer_wr,
	// Modem inputs.
	input  wire logic        clear_to_send_changed,
	input  wire logic        set_ready_changed,
	input  wire logic        ring_trailing_edge,
	input  wire logic        carrier_detect_changed,
	input  wire logic        handshake_status_rd,
	// Results.
	output logic             irq,
	output logic             baud16_tick,
	output logic             fifo_mode
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------

	// Receive trigger level in bytes.
	function automatic logic [4:0] trig_bytes(input logic [1:0] code);
		logic [4:0] r;
		r = `UIB_TRIG_00;
		case (code)
			2'b01: r = `UIB_TRIG_01;
			2'b10: r = `UIB_TRIG_10;
			2'b11: r = `UIB_TRIG_11;
			default: r = `UIB_TRIG_00;
		endcase
		return r;
	endfunction

	// Highest pending enabled source wins.
	function automatic uib_pkg::uib_ident_t pick(input logic ls,
		input logic tmo, input logic rd, input logic tx, input logic hs);
		uib_pkg::uib_ident_t r;
		r = uib_pkg::UIB_ID_NONE;
		if (ls) begin
			r = uib_pkg::UIB_ID_LINE;
		end else if (tmo) begin
			r = uib_pkg::UIB_ID_TMO;
		end else if (rd) begin
			r = uib_pkg::UIB_ID_RXD;
		end else if (tx) begin
			r = uib_pkg::UIB_ID_TXE;
		end else if (hs) begin
			r = uib_pkg::UIB_ID_HSK;
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------

	logic [3:0]  enable_q;
	logic [7:0]  div_low_q;
	logic [7:0]  div_high_q;
	logic [7:0]  scratch_q;
	logic [9:0]  config_q;
	logic        dph_wr_q;
	logic [11:0] dph_addr_q;
	logic        hreadyout_q;
	logic [31:0] hrdata_q;
	logic        ls_pend_q;
	logic        tmo_pend_q;
	logic        txe_pend_q;
	logic        hsk_pend_q;
	logic        irq_q;
	logic [2:0]  ref_sync_q;
	logic        ref_level_q;
	logic [3:0]  pre_cnt_q;
	logic [15:0] div_cnt_q;
	logic        tick_q;
	logic [15:0] tmo_cnt_q;

	logic        fifo_en;
	logic        high_speed;
	logic        rxd_level;
	logic        hsk_level;
	logic        ls_set;
	logic        tmo_restart;
	logic        addr_ok;
	logic        rd_ident;
	logic        ref_rise;
	logic        gen_tick;
	logic [15:0] divisor;
	uib_pkg::uib_ident_t ident;

	assign fifo_en    = config_q[`UIB_CFG_FIFO_EN];
	assign high_speed = &config_q[`UIB_CFG_HS_HI:`UIB_CFG_HS_LO];
	assign divisor    = {div_high_q, div_low_q};
	assign ls_set     = overrun_flag | parity_error_flag |
		missing_stop_flag | break_detect_flag;
	assign hsk_level  = clear_to_send_changed | set_ready_changed |
		ring_trailing_edge | carrier_detect_changed;
	assign rxd_level  = fifo_en ?
		(rx_fifo_count >= trig_bytes(config_q[`UIB_CFG_TRIG_HI:
		`UIB_CFG_TRIG_LO])) : rx_data_ready;
	assign tmo_restart = !fifo_en || rx_fifo_count == 5'h00 || rx_push ||
		receive_buffer_rd;
	assign ident = pick(ls_pend_q & enable_q[2],
		tmo_pend_q & enable_q[0], rxd_level & enable_q[0],
		txe_pend_q & enable_q[1], hsk_pend_q & enable_q[3]);

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------

	assign addr_ok  = hsel & hready & htrans[1];
	assign rd_ident = addr_ok & ~hwrite &
		(haddr[11:0] == `UIB_OFS_IDENT);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dph_wr_q    <= 1'b0;
			dph_addr_q  <= 12'h000;
			hreadyout_q <= 1'b0;
		end else if (ce) begin
			hreadyout_q <= 1'b1;
			if (hready) begin
				dph_wr_q   <= addr_ok & hwrite;
				dph_addr_q <= haddr[11:0];
			end
		end
	end

	// Read data is prepared in the address phase so it stands in the data
	// phase; unmapped addresses read zero.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (ce && addr_ok && !hwrite) begin
			if (haddr[11:0] == `UIB_OFS_IDENT) begin
				hrdata_q <= {24'h00_0000, {2{fifo_en}}, 2'b00,
					ident[3] & fifo_en, ident[2:0]};
			end else if (haddr[11:0] == `UIB_OFS_ENABLE) begin
				hrdata_q <= {28'h000_0000, enable_q};
			end else if (haddr[11:0] == `UIB_OFS_DIV_LOW) begin
				hrdata_q <= {24'h00_0000, div_low_q};
			end else if (haddr[11:0] == `UIB_OFS_DIV_HIGH) begin
				hrdata_q <= {24'h00_0000, div_high_q};
			end else if (haddr[11:0] == `UIB_OFS_SCRATCH) begin
				hrdata_q <= {24'h00_0000, scratch_q};
			end else if (haddr[11:0] == `UIB_OFS_CONFIG) begin
				hrdata_q <= {22'h0_0000, config_q};
			end else begin
				hrdata_q <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			enable_q   <= `UIB_RST_ENABLE;
			div_low_q  <= `UIB_RST_DIV_LOW;
			div_high_q <= `UIB_RST_DIV_HIGH;
			scratch_q  <= `UIB_RST_SCRATCH;
			config_q   <= `UIB_RST_CONFIG;
		end else if (ce && dph_wr_q && hready) begin
			if (dph_addr_q == `UIB_OFS_ENABLE) begin
				enable_q <= hwdata[3:0];
			end else if (dph_addr_q == `UIB_OFS_DIV_LOW) begin
				div_low_q <= hwdata[7:0];
			end else if (dph_addr_q == `UIB_OFS_DIV_HIGH) begin
				div_high_q <= hwdata[7:0];
			end else if (dph_addr_q == `UIB_OFS_SCRATCH) begin
				scratch_q <= hwdata[7:0];
			end else if (dph_addr_q == `UIB_OFS_CONFIG) begin
				config_q <= hwdata[9:0] & 10'(`UIB_CFG_MASK);
			end
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata    = hrdata_q;
	assign hresp     = 1'b0;

	// ---------------------------------------------------------------
	// Interrupt sources
	// ---------------------------------------------------------------

	// Set wins over clear on every sticky source except the time-out, where a receive buffer read wins.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ls_pend_q <= 1'b0;
		end else if (ce) begin
			if (ls_set) begin
				ls_pend_q <= 1'b1;
			end else if (line_status_rd) begin
				ls_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			txe_pend_q <= 1'b0;
		end else if (ce) begin
			if (tx_empty_evt) begin
				txe_pend_q <= 1'b1;
			end else if (transmit_buffer_wr ||
				(rd_ident && ident == uib_pkg::UIB_ID_TXE)) begin
				txe_pend_q <= 1'b0;
			end
		end
	end

	// Modem changes stay pending until the host reads handshake status.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hsk_pend_q <= 1'b0;
		end else if (ce) begin
			if (hsk_level) begin
				hsk_pend_q <= 1'b1;
			end else if (handshake_status_rd) begin
				hsk_pend_q <= 1'b0;
			end
		end
	end

	// Time-out counts 16x ticks while data waits untouched.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tmo_cnt_q  <= 16'h0000;
			tmo_pend_q <= 1'b0;
		end else if (ce) begin
			if (tmo_restart) begin
				tmo_cnt_q <= 16'h0000;
			end else if (tick_q && tmo_cnt_q != TMO_TICKS[15:0]) begin
				tmo_cnt_q <= tmo_cnt_q + 16'h0001;
			end
			// Set only as the count reaches its end, so that a read of the
			// receive buffer at a saturated count really clears it.
			if (!tmo_restart && tick_q &&
				tmo_cnt_q == 16'(TMO_TICKS - 1)) begin
				tmo_pend_q <= 1'b1;
			end else if (receive_buffer_rd || !fifo_en) begin
				tmo_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= config_q[`UIB_CFG_IRQ_OUT_EN] &
				(ident != uib_pkg::UIB_ID_NONE);
		end
	end

	assign irq       = irq_q;
	assign fifo_mode = fifo_en;

	// ---------------------------------------------------------------
	// Baud generator
	// ---------------------------------------------------------------

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ref_sync_q  <= 3'b000;
			ref_level_q <= 1'b0;
		end else if (ce) begin
			ref_sync_q <= {ref_sync_q[1:0], ref_clk_24m};
			if (ref_sync_q[2] == ref_sync_q[1]) begin
				ref_level_q <= ref_sync_q[2];
			end
		end
	end

	assign ref_rise = ~ref_level_q & ref_sync_q[2] & ref_sync_q[1];
	assign gen_tick = ref_rise &
		(high_speed || pre_cnt_q == 4'(PRESCALE - 1));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pre_cnt_q <= 4'h0;
		end else if (ce && ref_rise) begin
			if (high_speed || pre_cnt_q == 4'(PRESCALE - 1)) begin
				pre_cnt_q <= 4'h0;
			end else begin
				pre_cnt_q <= pre_cnt_q + 4'h1;
			end
		end
	end

	// A divisor of zero behaves as one.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div_cnt_q <= 16'h0001;
			tick_q    <= 1'b0;
		end else if (ce) begin
			tick_q <= 1'b0;
			if (gen_tick) begin
				if (div_cnt_q <= 16'h0001) begin
					div_cnt_q <= divisor;
					tick_q    <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q - 16'h0001;
				end
			end
		end
	end

	assign baud16_tick = tick_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------

	property p_ident_fifo_bits;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && rd_ident && fifo_en) |=> (hrdata_q[7:6] == 2'b11);
	endproperty
	a_ident_fifo_bits: assert property (p_ident_fifo_bits)
		else $error("Ident bits 7:6 not set in FIFO mode.");

	property p_ident_zero_bits;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && rd_ident) |=> (hrdata_q[5:4] == 2'b00) &&
			(fifo_en || !hrdata_q[3]);
	endproperty
	a_ident_zero_bits: assert property (p_ident_zero_bits)
		else $error("Ident reserved or time-out bit wrong.");

	property p_ident_none;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && rd_ident) |=>
			(hrdata_q[0] == ($past(ident) == uib_pkg::UIB_ID_NONE));
	endproperty
	a_ident_none: assert property (p_ident_none)
		else $error("Ident bit 0 does not show idle state.");

	property p_enable_upper;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && addr_ok && !hwrite && haddr[11:0] == `UIB_OFS_ENABLE)
			|=> (hrdata_q[31:4] == 28'h000_0000);
	endproperty
	a_enable_upper: assert property (p_enable_upper)
		else $error("Enable upper bits not zero.");

	property p_all_masked;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && enable_q == 4'h0) |=> !irq_q;
	endproperty
	a_all_masked: assert property (p_all_masked)
		else $error("Interrupt raised with all sources disabled.");

	property p_master_gate;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && !config_q[`UIB_CFG_IRQ_OUT_EN]) |=> !irq_q;
	endproperty
	a_master_gate: assert property (p_master_gate)
		else $error("Interrupt driven while output disabled.");

	property p_line_set;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && ls_set) |=> ls_pend_q;
	endproperty
	a_line_set: assert property (p_line_set)
		else $error("Line error lost.");

	property p_txe_clear;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && transmit_buffer_wr && !tx_empty_evt) |=> !txe_pend_q;
	endproperty
	a_txe_clear: assert property (p_txe_clear)
		else $error("Tx empty not cleared by write.");

	property p_scratch;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && dph_wr_q && hready && dph_addr_q == `UIB_OFS_SCRATCH)
			|=> (scratch_q == $past(hwdata[7:0]));
	endproperty
	a_scratch: assert property (p_scratch)
		else $error("Scratch did not store write.");

	property p_timeout;
		@(posedge clk_sys) disable iff (!resetn)
		(ce && fifo_en && rx_fifo_count != 5'h00 && !receive_buffer_rd &&
			tmo_cnt_q == TMO_TICKS[15:0]) |=> tmo_pend_q;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("Time-out not raised.");

	c_irq: cover property (@(posedge clk_sys) disable iff (!resetn)
		!irq_q ##1 irq_q);
	c_tmo: cover property (@(posedge clk_sys) disable iff (!resetn)
		!tmo_pend_q ##1 tmo_pend_q);
	c_tick_hs: cover property (@(posedge clk_sys) disable iff (!resetn)
		tick_q && high_speed);

endmodule // uib_top

`default_nettype wire

// >>> verif/uib_line_model.sv
// Purpose: Line-side model: free 24 MHz reference, tick spacing monitor.
// Assumes: The reference runs free, as a crystal does.
// Notes:   A 42 ns period stands in for 24 MHz on the 1 ns grid.
`timescale 1ns/1ns
`default_nettype none

module uib_line_model (
	// Clocks.
	input  wire logic      clk_sys,
	output var logic       ref_clk_24m,
	// Generator output and its measured spacing.
	input  wire logic      baud16_tick,
	output var int unsigned gap,
	output var int unsigned ticks
);
	int unsigned edges;
	int unsigned last;

	initial begin
		ref_clk_24m = 1'b0;
		gap = 0;
		ticks = 0;
		edges = 0;
		last = 0;
	end

	always #21 ref_clk_24m = ~ref_clk_24m;

	always @(posedge ref_clk_24m) begin
		edges <= edges + 1;
	end

	// Reference edges between two ticks give the whole divide ratio.
	always @(posedge clk_sys) begin
		if (baud16_tick === 1'b1) begin
			gap <= edges - last;
			last <= edges;
			ticks <= ticks + 1;
		end
	end
endmodule // uib_line_model
`default_nettype wire

// >>> verif/uib_top_tb.sv
// Purpose: Self-checking bench for the ident, enable and baud block.
// Assumes: Zero-wait AHB-Lite slave; time-out shortened to 8 ticks.
// Notes:   Tick spacing is judged with one reference edge of slack.
`include "uib_params.svh"
`timescale 1ns/1ns
`default_nettype none

module uib_top_tb;
	logic        clk_sys = 0, resetn = 0, ce = 1, hsel = 1, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hready, hreadyout, hresp, ref_clk_24m, irq;
	logic        baud16_tick, fifo_mode, line_status_rd = 0;
	logic        rx_data_ready = 0, rx_push = 0, receive_buffer_rd = 0;
	logic        tx_empty_evt = 0, transmit_buffer_wr = 0;
	logic        handshake_status_rd = 0;
	logic [4:0]  rx_fifo_count = 0;
	logic [3:0]  lf = 0, mf = 0;
	int unsigned gap, ticks;
	int          n_fail = 0, n_checks = 0;
	wire logic   overrun_flag = lf[0], parity_error_flag = lf[1];
	wire logic   missing_stop_flag = lf[2], break_detect_flag = lf[3];
	wire logic   clear_to_send_changed = mf[0], set_ready_changed = mf[1];
	wire logic   ring_trailing_edge = mf[2];
	wire logic   carrier_detect_changed = mf[3];
	assign hready = hreadyout;

	uib_top #(.TMO_TICKS(8)) i_uib_top (.*);
	uib_line_model i_uib_line_model (.*);

	always #5 clk_sys = ~clk_sys;

	//------------------------------------------------------------
	// Bus cycles and comparison.
	//------------------------------------------------------------
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		htrans <= uib_pkg::UIB_TR_NONSEQ;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		do step(1); while (hreadyout !== 1'b1 && ++n < 50);
		htrans <= uib_pkg::UIB_TR_IDLE;
		hwdata <= wd;
		do step(1); while (hreadyout !== 1'b1 && ++n < 100);
		if (hreadyout !== 1'b1)
			n_fail++;
		rd = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask

	task automatic rc(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0000_0000, v);
		chk(nm, v, e);
	endtask

	//------------------------------------------------------------
	// Scenarios.
	//------------------------------------------------------------
	task automatic t_regs;
		rc("div_lo", `UIB_OFS_DIV_LOW, 32'h0000_0001);
		rc("div_hi", `UIB_OFS_DIV_HIGH, 32'h0000_0000);
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0001);
		wr(`UIB_OFS_ENABLE, 32'hFFFF_FFFF);
		rc("enable", `UIB_OFS_ENABLE, 32'h0000_000F);
		wr(`UIB_OFS_SCRATCH, 32'h0000_00A5);
		rc("scratch", `UIB_OFS_SCRATCH, 32'h0000_00A5);
		wr(`UIB_OFS_SCRATCH, 32'h0000_005A);
		rc("scratch", `UIB_OFS_SCRATCH, 32'h0000_005A);
		chk("hresp", {31'h0, hresp}, 32'h0000_0000);
		// A line error while the clock enable is low must not be taken.
		ce <= 1'b0;
		lf <= 4'h1;
		step(2);
		lf <= 4'h0;
		ce <= 1'b1;
		rc("ident_frozen", `UIB_OFS_IDENT, 32'h0000_0001);
		wr(12'h018, 32'hFFFF_FFFF);
		rc("unmapped", 12'h018, 32'h0000_0000);
		wr(`UIB_OFS_CONFIG, 32'hFFFF_FFFF);
		rc("ident", `UIB_OFS_IDENT, 32'h0000_00C1);
		chk("fifo_mode", {31'h0, fifo_mode}, 32'h0000_0001);
		wr(`UIB_OFS_CONFIG, 32'h0000_0000);
	endtask

	// For each of four bits, a line error, then a modem change, raised and cleared.
	task automatic t_sources;
		wr(`UIB_OFS_CONFIG, 32'h0000_0009);
		for (int i = 0; i < 4; i++) begin
			wr(`UIB_OFS_ENABLE, 32'h0000_0004);
			lf <= 4'h1 << i;
			step(1);
			lf <= 4'h0;
			rc("ident", `UIB_OFS_IDENT, 32'h0000_00C6);
			chk("irq", {31'h0, irq}, 32'h0000_0001);
			line_status_rd <= 1'b1;
			step(1);
			line_status_rd <= 1'b0;
			rc("ident", `UIB_OFS_IDENT, 32'h0000_00C1);
			wr(`UIB_OFS_ENABLE, 32'h0000_0008);
			mf <= 4'h1 << i;
			step(1);
			rc("ident", `UIB_OFS_IDENT, 32'h0000_00C0);
			chk("irq", {31'h0, irq}, 32'h0000_0001);
			mf <= 4'h0;
			handshake_status_rd <= 1'b1;
			step(1);
			handshake_status_rd <= 1'b0;
			rc("ident", `UIB_OFS_IDENT, 32'h0000_00C1);
		end
	endtask

	// All four pending at once, in non-FIFO mode.
	task automatic t_prio;
		wr(`UIB_OFS_CONFIG, 32'h0000_0008);
		wr(`UIB_OFS_ENABLE, 32'h0000_000F);
		lf <= 4'h2;
		tx_empty_evt <= 1'b1;
		mf <= 4'h4;
		rx_data_ready <= 1'b1;
		step(1);
		lf <= 4'h0;
		tx_empty_evt <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0006);
		line_status_rd <= 1'b1;
		step(1);
		line_status_rd <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0004);
		rx_data_ready <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0002);
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0000);
		wr(`UIB_OFS_ENABLE, 32'h0000_0007);
		step(3);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		wr(`UIB_OFS_ENABLE, 32'h0000_0008);
		step(3);
		chk("irq", {31'h0, irq}, 32'h0000_0001);
		wr(`UIB_OFS_CONFIG, 32'h0000_0000);
		step(3);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		mf <= 4'h0;
		handshake_status_rd <= 1'b1;
		step(1);
		handshake_status_rd <= 1'b0;
		wr(`UIB_OFS_CONFIG, 32'h0000_0008);
		wr(`UIB_OFS_ENABLE, 32'h0000_000F);
		tx_empty_evt <= 1'b1;
		step(1);
		tx_empty_evt <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0002);
		transmit_buffer_wr <= 1'b1;
		step(1);
		transmit_buffer_wr <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_0001);
	endtask

	task automatic t_trig;
		logic [4:0] lv[4];
		lv = '{5'h01, 5'h04, 5'h08, 5'h0E};
		wr(`UIB_OFS_ENABLE, 32'h0000_0001);
		for (int c = 0; c < 4; c++) begin
			wr(`UIB_OFS_CONFIG, 32'h0000_0009 | (c << 6));
			rx_fifo_count <= lv[c] - 5'h01;
			rx_push <= 1'b1;
			step(1);
			rx_push <= 1'b0;
			rc("ident", `UIB_OFS_IDENT, 32'h0000_00C1);
			rx_fifo_count <= lv[c];
			rx_push <= 1'b1;
			step(1);
			rx_push <= 1'b0;
			rc("ident", `UIB_OFS_IDENT, 32'h0000_00C4);
		end
		rx_fifo_count <= 5'h00;
	endtask

	task automatic t_tmo;
		logic [31:0] v;
		int          n;
		n = 0;
		wr(`UIB_OFS_CONFIG, 32'h0000_0349);
		rx_fifo_count <= 5'h02;
		rx_push <= 1'b1;
		step(1);
		rx_push <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_00C1);
		do bus(1'b0, `UIB_OFS_IDENT, 32'h0000_0000, v);
		while (v !== 32'h0000_00CC && ++n < 200);
		chk("ident", v, 32'h0000_00CC);
		receive_buffer_rd <= 1'b1;
		step(1);
		receive_buffer_rd <= 1'b0;
		rc("ident", `UIB_OFS_IDENT, 32'h0000_00C1);
		rx_fifo_count <= 5'h00;
	endtask

	task automatic t_baud(input logic [31:0] cfg, input logic [15:0] d,
		input int unsigned e);
		int unsigned t0;
		int          n;
		n = 0;
		wr(`UIB_OFS_CONFIG, cfg);
		wr(`UIB_OFS_DIV_LOW, {24'h00_0000, d[7:0]});
		wr(`UIB_OFS_DIV_HIGH, {24'h00_0000, d[15:8]});
		t0 = ticks;
		while (ticks < t0 + 3 && n < 20000) begin
			step(1);
			n++;
		end
		chk("baud_ticks", {31'h0, ticks >= t0 + 3},
			32'h0000_0001);
		chk("baud_gap", {31'h0, gap + 1 >= e && gap <= e + 1},
			32'h0000_0001);
	endtask

	//------------------------------------------------------------
	// Sequence, watchdog and verdict.
	//------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		step(2);
		resetn <= 1'b1;
		step(1);
		t_regs;
		t_sources;
		t_prio;
		t_trig;
		t_tmo;
		t_baud(32'h0000_0000, 16'h0001, 13);
		t_baud(32'h0000_0000, 16'h000C, 156);
		t_baud(32'h0000_0300, 16'h001A, 26);
		t_baud(32'h0000_0300, 16'h0100, 256);
		stop_test;
	end

	initial begin
		step(60000);
		n_fail++;
		stop_test;
	end
endmodule // uib_top_tb
`default_nettype wire
